// ### load_exec_pkg.sv
// Shared constants for the dual and exclusive load executor.
// Assumes a single 50 MHz clock domain and an AHB-Lite register port.
package load_exec_pkg;

	// Register map, byte addresses
	localparam logic [11:0] REGFILE_BASE   = 12'h000;
	localparam logic [11:0] REGFILE_LAST   = 12'h03C;
	localparam logic [11:0] INSTR_OFFSET   = 12'h040;
	localparam logic [11:0] CTRL_OFFSET    = 12'h044;
	localparam logic [11:0] STATUS_OFFSET  = 12'h048;

	// Control and status fields
	localparam int CTRL_COND_BIT    = 0;
	localparam int ST_BUSY_BIT      = 0;
	localparam int ST_DONE_BIT      = 1;
	localparam int ST_SKIPPED_BIT   = 2;
	localparam int ST_UNPRED_BIT    = 3;
	localparam int ST_RELATED_BIT   = 4;
	localparam int ST_USAGE_BIT     = 5;
	localparam int ST_MEMMAN_BIT    = 6;
	localparam int ST_BUSERR_BIT    = 7;
	localparam int ST_UNKNOWN_BIT   = 8;

	// Reset values
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
	localparam logic [31:0] INSTR_RESET  = 32'h0000_0000;
	localparam logic [31:0] WORD_RESET   = 32'h0000_0000;

	// Encoding fragments
	localparam logic [6:0]  DUAL_TOP      = 7'h74;
	localparam logic [11:0] EXCL_WORD_TOP = 12'hE85;
	localparam logic [11:0] EXCL_BH_TOP   = 12'hE8D;
	localparam logic [3:0]  EXCL_BYTE_OP  = 4'h4;
	localparam logic [3:0]  EXCL_HALF_OP  = 4'h5;
	localparam logic [3:0]  REG_SP        = 4'hD;
	localparam logic [3:0]  REG_PC        = 4'hF;

	// Access sizes on the memory port
	localparam logic [1:0]  SIZE_BYTE     = 2'h0;
	localparam logic [1:0]  SIZE_HALF     = 2'h1;
	localparam logic [1:0]  SIZE_WORD     = 2'h2;
	localparam logic [31:0] WORD_STEP     = 32'h0000_0004;

	// AHB-Lite encodings
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic        HRESP_OKAY    = 1'b0;

	typedef enum logic [2:0] {
		KIND_NONE,
		KIND_DUAL_IMM,
		KIND_DUAL_LIT,
		KIND_EXCL_WORD,
		KIND_EXCL_BYTE,
		KIND_EXCL_HALF
	} kind_t;

endpackage

// ### load_decode.sv
// Combinational decode of one 32-bit load instruction into operand fields.
// Assumes the first halfword sits in the upper half of the instruction word.
`timescale 1ns/10ps
`default_nettype none
module load_decode (
	// Instruction
	input  wire logic [15:0]          hw1,
	input  wire logic [15:0]          hw2,
	// Decoded fields
	output var load_exec_pkg::kind_t  kind,
	output logic      [3:0]           t,
	output logic      [3:0]           t2,
	output logic      [3:0]           n,
	output logic      [31:0]          imm32,
	output logic                      add,
	output logic                      index,
	output logic                      wback,
	output logic                      unpred,
	output logic                      related
);
	import load_exec_pkg::*;

	function automatic logic badDest(input logic [3:0] r);
		badDest = (r == REG_SP) || (r == REG_PC);
	endfunction

	always_comb begin
		kind    = KIND_NONE;
		t       = hw2[15:12];
		t2      = hw2[11:8];
		n       = hw1[3:0];
		imm32   = {22'h0, hw2[7:0], 2'b00};
		add     = 1'b1;
		index   = 1'b1;
		wback   = 1'b0;
		unpred  = 1'b0;
		related = 1'b0;
		// Exclusives first: they fill the dual pattern's index and writeback clear space
		if (hw1[15:4] == EXCL_WORD_TOP) begin
			kind   = KIND_EXCL_WORD;
			unpred = badDest(t) || (n == REG_PC);
		end else if (hw1[15:4] == EXCL_BH_TOP &&
				(hw2[7:4] == EXCL_BYTE_OP || hw2[7:4] == EXCL_HALF_OP)) begin
			kind   = (hw2[7:4] == EXCL_BYTE_OP) ? KIND_EXCL_BYTE : KIND_EXCL_HALF;
			imm32  = WORD_RESET;
			unpred = badDest(t) || (n == REG_PC);
		end else if (hw1[15:9] == DUAL_TOP && hw1[6] && hw1[4]) begin
			add     = hw1[7];
			related = !hw1[8] && !hw1[5];
			unpred  = badDest(t) || badDest(t2) || (t == t2);
			if (n == REG_PC) begin
				kind   = KIND_DUAL_LIT;
				unpred = unpred || hw1[5];
			end else begin
				kind   = KIND_DUAL_IMM;
				index  = hw1[8];
				wback  = hw1[5];
				unpred = unpred || (hw1[5] && (n == t || n == t2));
			end
		end
	end

endmodule // load_decode
`default_nettype wire

// ### load_dual_exclusive_exec.sv
// Executor for dual-word and exclusive loads, with its register file on AHB-Lite.
// Assumes a memory system on the same clock that answers each read with memAck.
//
// How it works
// - Dual immediate: offset address is base plus or minus offset; index picks it.
// - Dual load reads aligned word at address, then the word four bytes higher.
// - With writeback, base takes the offset address after both words arrive.
// - Dual immediate offset is a multiple of four, 0 to 1020, either sign.
// - Add bit alone gives the sign, so plus zero and minus zero differ.
// - Stack pointer is a valid base; program counter only in plain offset form.
// - Literal dual load with program counter not word aligned is unpredictable.
// - Literal offset is the 8-bit field shifted left two, zero-extended.
// - Literal address is program counter plus or minus offset; two words loaded.
// - Literal writeback set is unpredictable; index and writeback clear is other group.
// - Dual load unpredictable for destination 13 or 15 or equal destinations.
// - Literal offset is a multiple of four between minus and plus 1020.
// - Exclusive word: base plus offset, arm watch for four bytes, load word.
// - Exclusive word offset is 0 to 1020 by fours; stack pointer base allowed.
// - Each exclusive load arms local watch; memory marks shareable ones globally. Here a misaligned one takes a usage fault without arming.
// - Exclusive byte: base address, arm one byte, zero-extend into destination.
// - Exclusive halfword: base address, arm two bytes, zero-extend halfword.
// - Exclusive load unpredictable for destination 13 or 15 or base 15.
//
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module load_dual_exclusive_exec (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Memory read port
	output logic             memReq,
	output logic      [31:0] memAddr,
	output logic      [1:0]  memSize,
	input  wire logic [31:0] memRdata,
	input  wire logic        memAck,
	input  wire logic        memProtErr,
	input  wire logic        memBusErr,
	// Exclusive watch arming
	output logic             exclArm,
	output logic      [31:0] exclAddr,
	output logic      [1:0]  exclSize,
	// Fault pulses
	output logic             usageFault,
	output logic             memManageFault,
	output logic             busFault
);
	import load_exec_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_READ1,
		ST_READ2,
		ST_FINISH
	} state_t;

	state_t      state;
	logic [31:0] regs [16];
	logic [31:0] instr;
	logic [31:0] ctrl;
	logic [8:0]  status;
	logic        startReq;

	// Latched operands
	kind_t       kindQ;
	logic [3:0]  tQ;
	logic [3:0]  t2Q;
	logic [3:0]  nQ;
	logic [31:0] immQ;
	logic        addQ;
	logic        indexQ;
	logic        wbackQ;
	logic [31:0] offsetAddrQ;
	logic [31:0] addrQ;

	// Decoder outputs
	kind_t       decKind;
	logic [3:0]  decT;
	logic [3:0]  decT2;
	logic [3:0]  decN;
	logic [31:0] decImm;
	logic        decAdd;
	logic        decIndex;
	logic        decWback;
	logic        decUnpred;
	logic        decRelated;

	load_decode u_decode (
		.hw1     (instr[31:16]),
		.hw2     (instr[15:0]),
		.kind    (decKind),
		.t       (decT),
		.t2      (decT2),
		.n       (decN),
		.imm32   (decImm),
		.add     (decAdd),
		.index   (decIndex),
		.wback   (decWback),
		.unpred  (decUnpred),
		.related (decRelated)
	);

	// Address phase capture for the data phase
	logic        dpWrite;
	logic [11:0] dpAddr;
	logic        addrPhase;
	assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dpWrite <= 1'b0;
			dpAddr  <= 12'h000;
		end else begin
			dpWrite <= addrPhase && hwrite;
			dpAddr  <= haddr[11:0];
		end
	end

	function automatic logic [31:0] readReg(input logic [11:0] a);
		if (a >= REGFILE_BASE && a <= REGFILE_LAST && a[1:0] == 2'b00) begin
			readReg = regs[a[5:2]];
		end else if (a == INSTR_OFFSET) begin
			readReg = instr;
		end else if (a == CTRL_OFFSET) begin
			readReg = ctrl;
		end else if (a == STATUS_OFFSET) begin
			readReg = {23'h0, status};
		end else begin
			readReg = WORD_RESET;
		end
	endfunction

	// Zero wait states: read data prepared at the address phase edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hrdata    <= WORD_RESET;
			hreadyout <= 1'b0;
			hresp     <= HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
			if (addrPhase && !hwrite) begin
				hrdata <= readReg(haddr[11:0]);
			end
		end
	end

	// Instruction and control registers; a write to the instruction starts it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			instr    <= INSTR_RESET;
			ctrl     <= CTRL_RESET;
			startReq <= 1'b0;
		end else begin
			startReq <= 1'b0;
			if (dpWrite && dpAddr == INSTR_OFFSET && state == ST_IDLE && !startReq) begin
				instr    <= hwdata;
				startReq <= 1'b1;
			end else if (dpWrite && dpAddr == CTRL_OFFSET) begin
				ctrl <= {31'h0, hwdata[CTRL_COND_BIT]};
			end
		end
	end

	// Address arithmetic from latched operands
	logic [31:0] baseVal;
	logic [31:0] offsetAddr;
	logic [31:0] effAddr;
	logic        misaligned;
	logic [1:0]  accSize;
	logic        isDual;
	logic        isExcl;

	always_comb begin
		baseVal    = regs[nQ];
		offsetAddr = addQ ? (baseVal + immQ) : (baseVal - immQ);
		effAddr    = indexQ ? offsetAddr : baseVal;
		isDual     = (kindQ == KIND_DUAL_IMM) || (kindQ == KIND_DUAL_LIT);
		isExcl     = !isDual && (kindQ != KIND_NONE);
		accSize    = SIZE_WORD;
		if (kindQ == KIND_EXCL_BYTE) begin
			accSize = SIZE_BYTE;
		end else if (kindQ == KIND_EXCL_HALF) begin
			accSize = SIZE_HALF;
		end
		misaligned = 1'b0;
		if (accSize == SIZE_WORD) begin
			misaligned = effAddr[1:0] != 2'b00;
		end else if (accSize == SIZE_HALF) begin
			misaligned = effAddr[0];
		end
	end

	// Zero-extend narrow reads; memory returns data right-justified
	function automatic logic [31:0] extend(input logic [1:0] sz, input logic [31:0] d);
		if (sz == SIZE_BYTE) begin
			extend = {24'h0, d[7:0]};
		end else if (sz == SIZE_HALF) begin
			extend = {16'h0, d[15:0]};
		end else begin
			extend = d;
		end
	endfunction

	logic memErr;
	assign memErr = memProtErr || memBusErr;

	// Sequencer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state       <= ST_IDLE;
			kindQ       <= KIND_NONE;
			tQ          <= 4'h0;
			t2Q         <= 4'h0;
			nQ          <= 4'h0;
			immQ        <= WORD_RESET;
			addQ        <= 1'b1;
			indexQ      <= 1'b1;
			wbackQ      <= 1'b0;
			offsetAddrQ <= WORD_RESET;
			addrQ       <= WORD_RESET;
		end else begin
			case (state)
				ST_IDLE: begin
					if (startReq) begin
						kindQ  <= decKind;
						tQ     <= decT;
						t2Q    <= decT2;
						nQ     <= decN;
						immQ   <= decImm;
						addQ   <= decAdd;
						indexQ <= decIndex;
						wbackQ <= decWback;
						if (!ctrl[CTRL_COND_BIT] || decUnpred || decRelated ||
								decKind == KIND_NONE) begin
							state <= ST_FINISH;
						end else begin
							state <= ST_ADDR;
						end
					end
				end
				ST_ADDR: begin
					offsetAddrQ <= offsetAddr;
					addrQ       <= effAddr;
					if (kindQ == KIND_DUAL_LIT && baseVal[1:0] != 2'b00) begin
						state <= ST_FINISH;
					end else if (misaligned) begin
						state <= ST_FINISH;
					end else begin
						state <= ST_READ1;
					end
				end
				ST_READ1: begin
					if (memAck) begin
						if (memErr || !isDual) begin
							state <= ST_FINISH;
						end else begin
							addrQ <= addrQ + WORD_STEP;
							state <= ST_READ2;
						end
					end
				end
				ST_READ2: begin
					if (memAck) begin
						state <= ST_FINISH;
					end
				end
				ST_FINISH: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Memory request and exclusive arming, held in flops
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			memReq   <= 1'b0;
			memAddr  <= WORD_RESET;
			memSize  <= SIZE_WORD;
			exclArm  <= 1'b0;
			exclAddr <= WORD_RESET;
			exclSize <= SIZE_WORD;
		end else begin
			exclArm <= 1'b0;
			if (state == ST_ADDR && !misaligned &&
					!(kindQ == KIND_DUAL_LIT && baseVal[1:0] != 2'b00)) begin
				memReq  <= 1'b1;
				memAddr <= effAddr;
				memSize <= accSize;
				if (isExcl) begin
					// Armed in the same cycle the read is requested, so a racing store sees the watch
					exclArm  <= 1'b1;
					exclAddr <= effAddr;
					exclSize <= accSize;
				end
			end else if (state == ST_READ1 && memAck && isDual && !memErr) begin
				memAddr <= addrQ + WORD_STEP;
			end else if (memAck) begin
				memReq <= 1'b0;
			end
		end
	end

	// Register file: software writes only while the sequencer is idle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 16; i++) begin
				regs[i] <= WORD_RESET;
			end
		end else if (state == ST_READ1 && memAck && !memErr) begin
			regs[tQ] <= extend(memSize, memRdata);
		end else if (state == ST_READ2 && memAck && !memErr) begin
			regs[t2Q] <= memRdata;
			if (wbackQ) begin
				regs[nQ] <= offsetAddrQ;
			end
		end else if (dpWrite && state == ST_IDLE && !startReq &&
				dpAddr <= REGFILE_LAST && dpAddr[1:0] == 2'b00) begin
			regs[dpAddr[5:2]] <= hwdata;
		end
	end

	// Status and fault pulses; status clears when a new instruction starts
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			status         <= 9'h000;
			usageFault     <= 1'b0;
			memManageFault <= 1'b0;
			busFault       <= 1'b0;
		end else begin
			usageFault     <= 1'b0;
			memManageFault <= 1'b0;
			busFault       <= 1'b0;
			status[ST_BUSY_BIT] <= (state != ST_IDLE) || startReq;
			if (state == ST_IDLE && startReq) begin
				status[8:1] <= 8'h00;
				status[ST_SKIPPED_BIT] <= !ctrl[CTRL_COND_BIT];
				if (ctrl[CTRL_COND_BIT]) begin
					status[ST_UNPRED_BIT]  <= decUnpred;
					status[ST_RELATED_BIT] <= decRelated;
					status[ST_UNKNOWN_BIT] <= decKind == KIND_NONE;
				end
			end else if (state == ST_ADDR) begin
				if (kindQ == KIND_DUAL_LIT && baseVal[1:0] != 2'b00) begin
					status[ST_UNPRED_BIT] <= 1'b1;
				end else if (misaligned) begin
					status[ST_USAGE_BIT] <= 1'b1;
					usageFault           <= 1'b1;
				end
			end else if ((state == ST_READ1 || state == ST_READ2) && memAck) begin
				// Protection outranks a bus error when both are reported
				if (memProtErr) begin
					status[ST_MEMMAN_BIT] <= 1'b1;
					memManageFault        <= 1'b1;
				end else if (memBusErr) begin
					status[ST_BUSERR_BIT] <= 1'b1;
					busFault              <= 1'b1;
				end
			end else if (state == ST_FINISH) begin
				status[ST_DONE_BIT] <= 1'b1;
			end
		end
	end

endmodule // load_dual_exclusive_exec
`default_nettype wire

// ### load_exec_props.sv
// Checker for the memory and watch ports of the load executor.
// Assumes it is bound onto load_dual_exclusive_exec, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module load_exec_props (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// Memory port
	input wire logic        memReq,
	input wire logic [31:0] memAddr,
	input wire logic [1:0]  memSize,
	input wire logic        memAck,
	input wire logic        memProtErr,
	input wire logic        memBusErr,
	// Watch and faults
	input wire logic        exclArm,
	input wire logic [31:0] exclAddr,
	input wire logic [1:0]  exclSize,
	input wire logic        memManageFault,
	input wire logic        busFault
);
	import load_exec_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_arm_rise;
		exclArm |-> $rose(memReq);
	endproperty
	a_arm_rise: assert property (p_arm_rise) else $error("arm off request start");
	property p_arm_addr;
		exclArm |-> exclAddr == memAddr && exclSize == memSize;
	endproperty
	a_arm_addr: assert property (p_arm_addr) else $error("arm address differs");
	property p_hold;
		memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memSize);
	endproperty
	a_hold: assert property (p_hold) else $error("request moved before answer");
	// Only a dual load keeps the request up past an answer
	property p_step;
		memReq && memAck |=> !memReq || memAddr == $past(memAddr) + WORD_STEP;
	endproperty
	a_step: assert property (p_step) else $error("second word not four higher");
	property p_align;
		memReq |-> (memSize != SIZE_WORD || memAddr[1:0] == 2'h0)
			&& (memSize != SIZE_HALF || !memAddr[0]);
	endproperty
	a_align: assert property (p_align) else $error("misaligned read issued");
	property p_prot;
		memReq && memAck && memProtErr |-> ##[1:3] memManageFault;
	endproperty
	a_prot: assert property (p_prot) else $error("no protection fault");
	property p_bus;
		memReq && memAck && memBusErr && !memProtErr |-> ##[1:3] busFault;
	endproperty
	a_bus: assert property (p_bus) else $error("no bus fault");
	property p_stop;
		memReq && memAck && (memProtErr || memBusErr) |=> !memReq;
	endproperty
	a_stop: assert property (p_stop) else $error("read after error");
	c_arm: cover property (exclArm);
	c_dual: cover property (memReq && memAck ##1 memReq);
	c_bus: cover property (busFault);
endmodule // load_exec_props
bind load_dual_exclusive_exec load_exec_props load_exec_props_inst (
	.ref_clk, .rst, .memReq, .memAddr, .memSize, .memAck, .memProtErr, .memBusErr,
	.exclArm, .exclAddr, .exclSize, .memManageFault, .busFault
);
`default_nettype wire

// ### mem_model.sv
// Memory side model: answers each read after a set lag, errors on command.
// Assumes the executor holds memReq and memAddr until memAck.
`timescale 1ns/10ps
`default_nettype none
module mem_model (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Read port
	input  wire logic        memReq,
	input  wire logic [31:0] memAddr,
	output logic      [31:0] memRdata,
	output logic             memAck,
	output logic             memProtErr,
	output logic             memBusErr,
	// Bench controls
	input  wire logic [3:0]  lag,
	input  wire logic [1:0]  errMode
);
	logic [3:0] cnt;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt <= 4'h0;
			memAck <= 1'b0;
		end else if (!memReq || memAck) begin
			cnt <= 4'h0;
			memAck <= 1'b0;
		end else if (cnt == lag) begin
			memAck <= 1'b1;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
	// Upper half differs from address, so a missing zero extension shows
	// Between answers the bus shows the inverse, never stale data
	assign memRdata = (memAck ? memAddr : ~memAddr) ^ 32'hFFFF_0000;
	assign memProtErr = memAck && errMode == 2'h1;
	assign memBusErr = memAck && errMode == 2'h2;
endmodule // mem_model
`default_nettype wire

// ### load_dual_exclusive_exec_tb.sv
// Bench for the dual and exclusive load executor, registers over AHB-Lite.
// Assumes mem_model on the memory side and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module load_dual_exclusive_exec_tb;
	import load_exec_pkg::*;
	typedef struct {
		logic [31:0] ins;
		logic [15:0] nv;
		logic [15:0] ea;
		logic [15:0] wb;
		logic [8:0]  st;
		logic        c;
	} row_t;
	localparam logic [31:0] SENT = 32'h0BAD_0BAD;
	logic        ref_clk, rst, hsel, hwrite, hreadyout, hresp;
	logic        memReq, memAck, memProtErr, memBusErr, exclArm;
	logic        usageFault, memManageFault, busFault;
	logic [31:0] haddr, hwdata, hrdata, memAddr, memRdata, exclAddr, armA, s;
	logic [1:0]  htrans, memSize, exclSize, errMode, armS;
	logic [2:0]  hsize;
	logic [3:0]  lag;
	int          num_errors, tests_run, cyc, armCnt, flt;
	row_t rows[19] = '{
		'{32'hE9D1_23FF, 16'h1000, 16'h13FC, 16'h1000, 9'h000, 1'b1},
		'{32'hE971_2301, 16'h1000, 16'h0FFC, 16'h0FFC, 9'h000, 1'b1},
		'{32'hE8F1_2302, 16'h1000, 16'h1000, 16'h1008, 9'h000, 1'b1},
		'{32'hE97D_2300, 16'h1000, 16'h1000, 16'h1000, 9'h000, 1'b1},
		'{32'hE95F_23FF, 16'h2000, 16'h1C04, 16'h2000, 9'h000, 1'b1},
		'{32'hE9FF_2300, 16'h2000, 16'h0000, 16'h2000, 9'h008, 1'b1},
		'{32'hE95F_23FF, 16'h2002, 16'h0000, 16'h2002, 9'h008, 1'b1},
		'{32'hE9D1_2200, 16'h1000, 16'h0000, 16'h1000, 9'h008, 1'b1},
		'{32'hE9D1_D300, 16'h1000, 16'h0000, 16'h1000, 9'h008, 1'b1},
		'{32'hE9D1_2F00, 16'h1000, 16'h0000, 16'h1000, 9'h008, 1'b1},
		'{32'hE851_2FFF, 16'h1000, 16'h13FC, 16'h1000, 9'h000, 1'b1},
		'{32'hE8D1_2F4F, 16'h1003, 16'h1003, 16'h1003, 9'h000, 1'b1},
		'{32'hE8D1_2F5F, 16'h1002, 16'h1002, 16'h1002, 9'h000, 1'b1},
		'{32'hE85F_2F00, 16'h1000, 16'h0000, 16'h1000, 9'h008, 1'b1},
		'{32'hE851_FF00, 16'h1000, 16'h0000, 16'h1000, 9'h008, 1'b1},
		'{32'hE8D1_2F5F, 16'h1001, 16'h0000, 16'h1001, 9'h020, 1'b1},
		'{32'hE9D1_2300, 16'h1002, 16'h0000, 16'h1002, 9'h020, 1'b1},
		'{32'hE8D1_2300, 16'h1000, 16'h0000, 16'h1000, 9'h010, 1'b1},
		'{32'hE851_2F00, 16'h1000, 16'h0000, 16'h1000, 9'h004, 1'b0}
	};
	load_dual_exclusive_exec load_dual_exclusive_exec_inst (
		.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .memReq, .memAddr,
		.memSize, .memRdata, .memAck, .memProtErr, .memBusErr, .exclArm,
		.exclAddr, .exclSize, .usageFault, .memManageFault, .busFault
	);
	mem_model mem_model_inst (
		.ref_clk, .rst, .memReq, .memAddr, .memRdata, .memAck, .memProtErr,
		.memBusErr, .lag, .errMode
	);
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Hang guard well above the thousand or so cycles the run needs
	always @(posedge ref_clk) begin
		cyc++;
		if (exclArm === 1'b1) begin
			armA   <= exclAddr;
			armS   <= exclSize;
			armCnt <= armCnt + 1;
		end
		// Fault pulses tallied in separate hex digits, at most one each per load
		flt <= flt + (usageFault === 1'b1 ? 1 : 0) + (memManageFault === 1'b1 ? 16 : 0)
			+ (busFault === 1'b1 ? 256 : 0);
		if (cyc == 20000) begin
			num_errors++;
			results();
		end
	end
	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Entered just after a rising edge; holds each phase until hready
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		htrans <= HTRANS_NONSEQ;
		haddr <= {20'h0_0000, a};
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic run(input row_t r);
		logic [31:0] g;
		logic [31:0] v;
		logic [11:0] na;
		logic [1:0]  sz;
		logic        du, by, hf, ok, ar;
		int          a0, f0;
		// Index and writeback both clear is the exclusive group, not a dual
		du = r.ins[31:25] == DUAL_TOP && (r.ins[24] || r.ins[21]);
		by = r.ins[31:20] == EXCL_BH_TOP && r.ins[7:4] == EXCL_BYTE_OP;
		hf = r.ins[31:20] == EXCL_BH_TOP && r.ins[7:4] == EXCL_HALF_OP;
		ok = r.st == 9'h000;
		ar = !du && r.ea != 16'h0000;
		sz = by ? SIZE_BYTE : hf ? SIZE_HALF : SIZE_WORD;
		na = {6'h00, r.ins[19:16], 2'h0};
		v = {16'h0000, r.ea} ^ 32'hFFFF_0000;
		v = !ok ? SENT : by ? {24'h00_0000, v[7:0]} : hf ? {16'h0000, v[15:0]} : v;
		a0 = armCnt;
		f0 = flt;
		bus(1'b1, 12'h008, SENT, g);
		bus(1'b1, 12'h00C, SENT, g);
		bus(1'b1, na, {16'h0000, r.nv}, g);
		bus(1'b1, CTRL_OFFSET, {31'h0000_0000, r.c}, g);
		bus(1'b1, INSTR_OFFSET, r.ins, g);
		// Status trails the start by a cycle; polling at once shows the last result
		@(posedge ref_clk);
		do bus(1'b0, STATUS_OFFSET, 32'h0000_0000, g);
		while (g[ST_BUSY_BIT] !== 1'b0 || g[8:1] == 8'h00);
		chk(g & 32'h0000_01FC, {23'h00_0000, r.st});
		chk(32'(flt - f0), {23'h00_0000, r.st[7], 3'h0, r.st[6], 3'h0, r.st[5]});
		bus(1'b0, 12'h008, 32'h0000_0000, g);
		chk(g, v);
		v = ({16'h0000, r.ea} + WORD_STEP) ^ 32'hFFFF_0000;
		bus(1'b0, 12'h00C, 32'h0000_0000, g);
		chk(g, ok && du ? v : SENT);
		bus(1'b0, na, 32'h0000_0000, g);
		chk(g, {16'h0000, r.wb});
		chk(32'(armCnt - a0), {31'h0000_0000, ar});
		if (ar) begin
			chk(armA, {16'h0000, r.ea});
			chk({30'h0000_0000, armS}, {30'h0000_0000, sz});
		end
		$display("test %h done", r.ins);
	endtask
	initial begin
		rst = 1'b1;
		hsel = 1'b1;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		lag = 4'h0;
		errMode = 2'h0;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		for (int p = 0; p < 2; p++) begin
			lag <= 4'(p * 3);
			foreach (rows[i]) run(rows[i]);
		end
		// Faulting reads: arming still counts, nothing is written
		errMode <= 2'h1;
		run('{32'hE851_2F00, 16'h1000, 16'h1000, 16'h1000, 9'h040, 1'b1});
		errMode <= 2'h2;
		run('{32'hE9D1_2300, 16'h1000, 16'h0000, 16'h1000, 9'h080, 1'b1});
		errMode <= 2'h0;
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		bus(1'b0, 12'h008, 32'h0000_0000, s);
		chk(s, WORD_RESET);
		bus(1'b0, CTRL_OFFSET, 32'h0000_0000, s);
		chk(s, CTRL_RESET);
		bus(1'b0, STATUS_OFFSET, 32'h0000_0000, s);
		chk(s, 32'h0000_0000);
		chk({31'h0000_0000, hresp}, {31'h0000_0000, HRESP_OKAY});
		bus(1'b1, 12'h100, 32'hFFFF_FFFF, s);
		bus(1'b0, 12'h100, 32'h0000_0000, s);
		chk(s, 32'h0000_0000);
		$display("test reset and unmapped done");
		results();
	end
endmodule // load_dual_exclusive_exec_tb
`default_nettype wire
